// ==== design/accel_cfg.svh ====
// offsets, field positions, reset values and timing counts of the sample readout
`ifndef ACCEL_CFG_SVH
`define ACCEL_CFG_SVH

`define ADDR_X_LOW        8'h02
`define ADDR_X_HIGH       8'h03
`define ADDR_Y_LOW        8'h04
`define ADDR_Y_HIGH       8'h05
`define ADDR_Z_LOW        8'h06
`define ADDR_Z_HIGH       8'h07
`define ADDR_HEAT         8'h08
`define ADDR_SPAN         8'h0F
`define ADDR_BW           8'h10
`define ADDR_POWER        8'h11
`define ADDR_STREAM       8'h13
`define ADDR_SELFTEST     8'h32

`define POWER_LP_EN_BIT   4
`define STREAM_RAW_BIT    7
`define STREAM_LOCKDIS_BIT 6
`define ST_SIGN_BIT       2
`define ST_AMP_BIT        4

`define SPAN_RESET        8'h03
`define BW_RESET          5'h0F
`define SPAN_2G           4'h3
`define SPAN_4G           4'h5
`define SPAN_8G           4'h8
`define SPAN_16G          4'hC
`define BW_MIN            5'h08
`define BW_MAX            5'h0F

`define CLK_PERIOD_PS     4000
`define TICK_PS           500000000
`define TICK_CYC          ((`TICK_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define WAKE_SETTLE_PS    1800000000
`define WAKE_SETTLE_CYC   ((`WAKE_SETTLE_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define ST_WAIT_MS        50
`define ST_WAIT_CYC       (`ST_WAIT_MS * (1000000000 / `CLK_PERIOD_PS))
`define ST_MIN_XY_LSB     12'd205
`define ST_MIN_Z_LSB      12'd103

`endif

// ==== design/accel_pkg.sv ====
// types shared by the sensor readout device and its host controller
package accel_pkg;
    typedef logic [2:0][11:0] axis_vec_t;
    typedef enum logic [1:0] {PWR_NORMAL, PWR_SETTLE, PWR_ACTIVE, PWR_SLEEP} pwr_state_t;
    typedef enum logic [3:0] {
        H_IDLE, H_CMD, H_SPAN, H_ST_ON, H_WAIT, H_RD_LO, H_RD_HI, H_RD_END,
        H_ST_OFF, H_WAIT_OFF, H_DONE
    } host_state_t;
endpackage : accel_pkg

// ==== design/accel_reg_if.sv ====
// register link between the host controller and the sensor device
`timescale 1ns/1ps
`default_nettype none
interface accel_reg_if;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    modport dev  (input reg_addr, input reg_wdata, input reg_wr, input reg_rd, output reg_rdata);
    modport host (output reg_addr, output reg_wdata, output reg_wr, output reg_rd, input reg_rdata);
endinterface : accel_reg_if
`default_nettype wire

// ==== design/accel_device.sv ====
// sensor device: sample registers, locking, streams, power cycling, self-test controls
`timescale 1ns/1ps
`default_nettype none
`include "accel_cfg.svh"
module accel_device
    import accel_pkg::*;
#(
    parameter int unsigned TICK_CYC   = `TICK_CYC,
    parameter int unsigned SETTLE_CYC = `WAKE_SETTLE_CYC
) (
    input  wire logic      clk_sys_i,
    input  wire logic      rst_i,
    accel_reg_if.dev       bus,
    input  wire axis_vec_t raw_acc_i,
    input  wire axis_vec_t filt_acc_i,
    input  wire logic [7:0] heat_i,
    output logic           analog_pwr_o,
    output logic [1:0]     selftest_axis_o,
    output logic           selftest_sign_o,
    output logic           selftest_amp_o,
    output logic [3:0]     span_code_o,
    output logic           span_valid_o,
    output logic [4:0]     bw_eff_o
);
    ////////////////////////////////////////////////////////////////////////
    // configuration registers
    logic [7:0] span_q;
    logic [4:0] bw_q;
    logic [3:0] sleep_code_q;
    logic       lp_en_q;
    logic       raw_sel_q;
    logic       lock_dis_q;
    logic [1:0] st_axis_q;
    logic       st_sign_q;
    logic       st_amp_q;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            span_q       <= `SPAN_RESET;
            bw_q         <= `BW_RESET;
            sleep_code_q <= 4'h0;
            lp_en_q      <= 1'b0;
            raw_sel_q    <= 1'b0;
            lock_dis_q   <= 1'b0;
            st_axis_q    <= 2'h0;
            st_sign_q    <= 1'b0;
            st_amp_q     <= 1'b0;
        end else if (bus.reg_wr) begin
            case (bus.reg_addr)
                `ADDR_SPAN: span_q <= bus.reg_wdata;
                `ADDR_BW:   bw_q   <= bus.reg_wdata[4:0];
                `ADDR_POWER: begin
                    sleep_code_q <= bus.reg_wdata[3:0];
                    lp_en_q      <= bus.reg_wdata[`POWER_LP_EN_BIT];
                end
                `ADDR_STREAM: begin
                    raw_sel_q  <= bus.reg_wdata[`STREAM_RAW_BIT];
                    lock_dis_q <= bus.reg_wdata[`STREAM_LOCKDIS_BIT];
                end
                `ADDR_SELFTEST: begin
                    st_axis_q <= bus.reg_wdata[1:0];
                    st_sign_q <= bus.reg_wdata[`ST_SIGN_BIT];
                    st_amp_q  <= bus.reg_wdata[`ST_AMP_BIT];
                end
                default: ;
            endcase
        end
    end

    assign selftest_axis_o = st_axis_q;
    assign selftest_sign_o = st_sign_q;
    assign selftest_amp_o  = st_amp_q;
    assign span_code_o     = span_q[3:0];
    assign span_valid_o = (span_q[3:0] == `SPAN_2G) || (span_q[3:0] == `SPAN_4G) ||
                          (span_q[3:0] == `SPAN_8G) || (span_q[3:0] == `SPAN_16G);
    assign bw_eff_o = bw_q[4] ? `BW_MAX : (bw_q[3] ? bw_q : `BW_MIN);

    ////////////////////////////////////////////////////////////////////////
    // 0.5 ms timebase, free running on the device clock only
    logic [31:0] tb_cnt_q;
    logic        tick;
    assign tick = (tb_cnt_q == TICK_CYC - 1);
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) tb_cnt_q <= 32'h0;
        else if (tick) tb_cnt_q <= 32'h0;
        else tb_cnt_q <= tb_cnt_q + 32'h1;
    end

    // sleep length in timebase ticks; low codes all collapse to one tick
    function automatic logic [11:0] sleep_ticks(input logic [3:0] code);
        case (code)
            4'h6:    sleep_ticks = 12'd2;
            4'h7:    sleep_ticks = 12'd4;
            4'h8:    sleep_ticks = 12'd8;
            4'h9:    sleep_ticks = 12'd12;
            4'hA:    sleep_ticks = 12'd20;
            4'hB:    sleep_ticks = 12'd50;
            4'hC:    sleep_ticks = 12'd100;
            4'hD:    sleep_ticks = 12'd200;
            4'hE:    sleep_ticks = 12'd1000;
            4'hF:    sleep_ticks = 12'd2000;
            default: sleep_ticks = 12'd1;
        endcase
    endfunction : sleep_ticks

    ////////////////////////////////////////////////////////////////////////
    // periodic power cycling
    pwr_state_t  pwr_q;
    logic [11:0] sleep_cnt_q;
    logic [31:0] settle_cnt_q;
    logic        accept;

    assign accept = tick && (pwr_q == PWR_NORMAL || pwr_q == PWR_ACTIVE);

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            pwr_q        <= PWR_NORMAL;
            sleep_cnt_q  <= 12'h0;
            settle_cnt_q <= 32'h0;
        end else begin
            case (pwr_q)
                PWR_NORMAL: if (lp_en_q) pwr_q <= PWR_ACTIVE;
                PWR_ACTIVE: begin
                    if (!lp_en_q) begin
                        pwr_q <= PWR_NORMAL;
                    end else if (tick) begin
                        pwr_q       <= PWR_SLEEP;
                        sleep_cnt_q <= sleep_ticks(sleep_code_q);
                    end
                end
                PWR_SLEEP: begin
                    if (!lp_en_q || (tick && sleep_cnt_q == 12'd1)) begin
                        pwr_q        <= PWR_SETTLE;
                        settle_cnt_q <= 32'h0;
                    end else if (tick) begin
                        sleep_cnt_q <= sleep_cnt_q - 12'd1;
                    end
                end
                PWR_SETTLE: begin
                    if (settle_cnt_q == SETTLE_CYC - 1) pwr_q <= lp_en_q ? PWR_ACTIVE : PWR_NORMAL;
                    else settle_cnt_q <= settle_cnt_q + 32'h1;
                end
                default: pwr_q <= PWR_NORMAL;
            endcase
        end
    end

    assign analog_pwr_o = (pwr_q != PWR_SLEEP);

    ////////////////////////////////////////////////////////////////////////
    // stream selection: filtered updates every 2^(15-code) ticks
    logic [6:0] ftick_q;
    logic [2:0] fshift;
    logic [6:0] fmask;
    logic       upd;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) ftick_q <= 7'h0;
        else if (tick) ftick_q <= ftick_q + 7'h1;
    end

    assign fshift = 3'(`BW_MAX - bw_eff_o);
    assign fmask  = 7'((8'h01 << fshift) - 8'h01);
    assign upd = accept && (raw_sel_q || ((ftick_q & fmask) == 7'h0));

    ////////////////////////////////////////////////////////////////////////
    // sample registers with high-byte lock and fresh flags
    logic [2:0][11:0] data_q;
    logic [2:0][7:0]  high_q;
    logic [2:0]       lock_q;
    logic [2:0]       fresh_q;
    logic [7:0]       heat_q;
    logic [2:0]       rd_lo;
    logic [2:0]       rd_hi;
    axis_vec_t        src;

    assign src = raw_sel_q ? raw_acc_i : filt_acc_i;

    always_comb begin
        for (int a = 0; a < 3; a++) begin
            rd_lo[a] = bus.reg_rd && (bus.reg_addr == `ADDR_X_LOW + 8'(2 * a));
            rd_hi[a] = bus.reg_rd && (bus.reg_addr == `ADDR_X_HIGH + 8'(2 * a));
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            data_q  <= '0;
            high_q  <= '0;
            lock_q  <= 3'h0;
            fresh_q <= 3'h0;
            heat_q  <= 8'h00;
        end else begin
            if (upd) heat_q <= heat_i;
            for (int a = 0; a < 3; a++) begin
                if (upd) data_q[a] <= src[a];
                // upper half also held in the low-read cycle, unless locking is disabled, so both halves match
                if (upd && (lock_dis_q || !(lock_q[a] || rd_lo[a]))) high_q[a] <= src[a][11:4];
                if (rd_hi[a] || lock_dis_q) lock_q[a] <= 1'b0;
                else if (rd_lo[a]) lock_q[a] <= 1'b1;
                // a new sample in the read cycle keeps the flag set
                if (upd) fresh_q[a] <= 1'b1;
                else if (rd_lo[a] || rd_hi[a]) fresh_q[a] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port: data one cycle after the strobe, unmapped reads zero
    logic [7:0] rdata_q;
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q <= 8'h00;
        end else if (bus.reg_rd) begin
            case (bus.reg_addr)
                `ADDR_X_LOW:    rdata_q <= {data_q[0][3:0], 3'b000, fresh_q[0]};
                `ADDR_Y_LOW:    rdata_q <= {data_q[1][3:0], 3'b000, fresh_q[1]};
                `ADDR_Z_LOW:    rdata_q <= {data_q[2][3:0], 3'b000, fresh_q[2]};
                `ADDR_X_HIGH:   rdata_q <= high_q[0];
                `ADDR_Y_HIGH:   rdata_q <= high_q[1];
                `ADDR_Z_HIGH:   rdata_q <= high_q[2];
                `ADDR_HEAT:     rdata_q <= heat_q;
                `ADDR_SPAN:     rdata_q <= span_q;
                `ADDR_BW:       rdata_q <= {3'b000, bw_q};
                `ADDR_POWER:    rdata_q <= {3'b000, lp_en_q, sleep_code_q};
                `ADDR_STREAM:   rdata_q <= {raw_sel_q, lock_dis_q, 6'h00};
                `ADDR_SELFTEST: rdata_q <= {3'b000, st_amp_q, 1'b0, st_sign_q, st_axis_q};
                default:        rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end
    assign bus.reg_rdata = rdata_q;

endmodule : accel_device
`default_nettype wire

// ==== design/accel_host.sv ====
// host controller: register pass-through, ordered sample reads, self-test sequence
`timescale 1ns/1ps
`default_nettype none
`include "accel_cfg.svh"
module accel_host
    import accel_pkg::*;
#(
    parameter int unsigned WAIT_CYC = `ST_WAIT_CYC
) (
    input  wire logic       clk_sys_i,
    input  wire logic       rst_i,
    accel_reg_if.host       bus,
    input  wire logic       cmd_wr_i,
    input  wire logic       cmd_rd_i,
    input  wire logic [7:0] cmd_addr_i,
    input  wire logic [7:0] cmd_wdata_i,
    output logic [7:0]      cmd_rdata_o,
    output logic            cmd_rvalid_o,
    input  wire logic       acc_rd_i,
    input  wire logic [1:0] acc_axis_i,
    output logic [11:0]     acc_o,
    output logic            acc_fresh_o,
    output logic            acc_valid_o,
    input  wire logic       st_go_i,
    input  wire logic [1:0] st_axis_i,
    output logic            st_done_o,
    output logic            st_pass_o,
    output logic            busy_o
);
    host_state_t state_q;
    logic [7:0]  addr_q;
    logic [7:0]  wdata_q;
    logic        wr_q;
    logic        rd_q;
    logic [1:0]  axis_q;
    logic        in_st_q;
    logic        pol_q;
    logic [3:0]  lo_q;
    logic [11:0] pos_q;
    logic [31:0] wait_q;
    logic [11:0] diff;
    logic [11:0] sample;

    assign sample = {bus.reg_rdata, lo_q};
    assign diff   = pos_q - sample;
    assign busy_o = (state_q != H_IDLE);

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            state_q      <= H_IDLE;
            addr_q       <= 8'h00;
            wdata_q      <= 8'h00;
            wr_q         <= 1'b0;
            rd_q         <= 1'b0;
            axis_q       <= 2'h0;
            in_st_q      <= 1'b0;
            pol_q        <= 1'b0;
            lo_q         <= 4'h0;
            pos_q        <= 12'h000;
            wait_q       <= 32'h0;
            cmd_rdata_o  <= 8'h00;
            cmd_rvalid_o <= 1'b0;
            acc_o        <= 12'h000;
            acc_fresh_o  <= 1'b0;
            acc_valid_o  <= 1'b0;
            st_done_o    <= 1'b0;
            st_pass_o    <= 1'b0;
        end else begin
            wr_q         <= 1'b0;
            rd_q         <= 1'b0;
            cmd_rvalid_o <= 1'b0;
            acc_valid_o  <= 1'b0;
            st_done_o    <= 1'b0;
            case (state_q)
                H_IDLE: begin
                    if (st_go_i && st_axis_i != 2'h0) begin
                        state_q <= H_SPAN;
                        axis_q  <= st_axis_i;
                        in_st_q <= 1'b1;
                        pol_q   <= 1'b1;
                        addr_q  <= `ADDR_SPAN;
                        wdata_q <= {4'h0, `SPAN_8G};
                        wr_q    <= 1'b1;
                    end else if (acc_rd_i && acc_axis_i != 2'h0) begin
                        state_q <= H_RD_LO;
                        axis_q  <= acc_axis_i;
                        in_st_q <= 1'b0;
                    end else if (cmd_wr_i || cmd_rd_i) begin
                        state_q <= cmd_rd_i ? H_CMD : H_IDLE;
                        addr_q  <= cmd_addr_i;
                        axis_q  <= 2'h0;
                        wdata_q <= cmd_wdata_i;
                        wr_q    <= cmd_wr_i && !cmd_rd_i;
                        rd_q    <= cmd_rd_i;
                    end
                end
                H_CMD: state_q <= H_RD_END;
                H_SPAN, H_ST_ON: begin
                    state_q <= H_WAIT;
                    wait_q  <= 32'h0;
                    addr_q  <= `ADDR_SELFTEST;
                    wdata_q <= 8'((1 << `ST_AMP_BIT) | (pol_q << `ST_SIGN_BIT) | axis_q);
                    wr_q    <= 1'b1;
                end
                H_WAIT: begin
                    if (wait_q == WAIT_CYC - 1) state_q <= H_RD_LO;
                    else wait_q <= wait_q + 32'h1;
                end
                H_RD_LO: begin
                    state_q <= H_RD_HI;
                    addr_q  <= `ADDR_X_LOW + {5'h00, axis_q - 2'h1, 1'b0};
                    rd_q    <= 1'b1;
                end
                H_RD_HI: begin
                    state_q <= H_RD_END;
                    addr_q  <= addr_q + 8'h01;
                    rd_q    <= 1'b1;
                end
                H_RD_END: begin
                    if (rd_q) begin
                        // low byte on the link while the high byte is strobed
                        lo_q        <= bus.reg_rdata[7:4];
                        acc_fresh_o <= bus.reg_rdata[0];
                        state_q     <= H_RD_END;
                    end else if (in_st_q && pol_q) begin
                        pos_q   <= sample;
                        pol_q   <= 1'b0;
                        state_q <= H_ST_ON;
                    end else if (in_st_q) begin
                        st_pass_o <= (axis_q == 2'h3) ? (diff >= `ST_MIN_Z_LSB) : (diff >= `ST_MIN_XY_LSB);
                        state_q   <= H_ST_OFF;
                    end else if (axis_q != 2'h0) begin
                        // plain register reads clear the axis, so they never land here
                        acc_o       <= sample;
                        acc_valid_o <= 1'b1;
                        state_q     <= H_IDLE;
                    end else begin
                        cmd_rdata_o  <= bus.reg_rdata;
                        cmd_rvalid_o <= 1'b1;
                        state_q      <= H_IDLE;
                    end
                end
                H_ST_OFF: begin
                    state_q <= H_WAIT_OFF;
                    wait_q  <= 32'h0;
                    addr_q  <= `ADDR_SELFTEST;
                    wdata_q <= 8'h00;
                    wr_q    <= 1'b1;
                end
                H_WAIT_OFF: begin
                    if (wait_q == WAIT_CYC - 1) state_q <= H_DONE;
                    else wait_q <= wait_q + 32'h1;
                end
                H_DONE: begin
                    st_done_o <= 1'b1;
                    in_st_q   <= 1'b0;
                    state_q   <= H_IDLE;
                end
                default: state_q <= H_IDLE;
            endcase
        end
    end

    assign bus.reg_addr  = addr_q;
    assign bus.reg_wdata = wdata_q;
    assign bus.reg_wr    = wr_q;
    assign bus.reg_rd    = rd_q;

endmodule : accel_host
`default_nettype wire

// ==== sim/accel_readout_chk.sv ====
// assertions on the register link between host controller and sensor device
`timescale 1ns/1ps
`default_nettype none
module accel_readout_chk #(
    parameter int unsigned WAIT_CYC = 20
) (
    input wire logic       clk_sys_i,
    input wire logic       rst_i,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    logic [7:0]  span_q;
    logic [4:0]  bw_q;
    int unsigned st_cnt_q;
    logic        st_wr;
    assign st_wr = reg_wr && reg_addr == 8'h32;
    ////////////////////////////////////////////////////////////
    // shadows of the span and bandwidth settings so that read-back can be judged
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            span_q <= 8'h03;
            bw_q   <= 5'h0F;
        end else if (reg_wr && reg_addr == 8'h0F) begin
            span_q <= reg_wdata;
        end else if (reg_wr && reg_addr == 8'h10) begin
            bw_q <= reg_wdata[4:0];
        end
    end
    // saturating, so it stays small whatever the run length
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) st_cnt_q <= WAIT_CYC;
        else if (st_wr) st_cnt_q <= 0;
        else if (st_cnt_q < WAIT_CYC) st_cnt_q <= st_cnt_q + 1;
    end
    ////////////////////////////////////////////////////////////
    rdata_idle_a:
        assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside its slot");
    strobe_excl_a:
        assert property (!(reg_wr && reg_rd))
        else $error("write and read strobes together");
    low_pad_a:
        assert property (reg_rd && reg_addr inside {8'h02, 8'h04, 8'h06} |=> reg_rdata[3:1] == 3'h0)
        else $error("unused low byte bits not zero");
    span_back_a:
        assert property (reg_rd && reg_addr == 8'h0F |=> reg_rdata[3:0] == span_q[3:0])
        else $error("span code read-back differs");
    bw_back_a:
        assert property (reg_rd && reg_addr == 8'h10 |=> reg_rdata[4:0] == bw_q)
        else $error("bandwidth code read-back differs");
    st_amp_a:
        assert property (st_wr && reg_wdata[1:0] != 2'h0 |-> reg_wdata[4])
        else $error("self-test enabled with low amplitude");
    st_span_a:
        assert property (st_wr && reg_wdata[1:0] != 2'h0 |-> span_q[3:0] == 4'h8)
        else $error("self-test enabled outside 8g span");
    st_wait_a:
        assert property (reg_rd && reg_addr inside {[8'h02:8'h07]} |-> st_cnt_q >= WAIT_CYC - 1)
        else $error("sample read too soon after self-test change");
    cover property (st_wr && reg_wdata[1:0] == 2'h3);
    cover property (reg_rd && reg_addr == 8'h02 ##1 reg_rd && reg_addr == 8'h03);
    cover property (reg_wr && reg_addr == 8'h11 && reg_wdata[4]);
endmodule : accel_readout_chk
`default_nettype wire

// ==== sim/accel_sample_readout_selftest_tb.sv ====
// self-checking bench: host controller and sensor device joined over the register link
`timescale 1ns/1ps
`default_nettype none
module accel_sample_readout_selftest_tb;
    logic clk_sys_i = 1'b0, rst_i = 1'b1, cmd_wr_i = 1'b0, cmd_rd_i = 1'b0;
    logic acc_rd_i = 1'b0, st_go_i = 1'b0, cmd_rvalid_o, acc_fresh_o, acc_valid_o, st_done_o;
    logic st_pass_o, busy_o, analog_pwr_o, selftest_sign_o, selftest_amp_o, span_valid_o, fr;
    logic [1:0] acc_axis_i = 2'h0, st_axis_i = 2'h0, selftest_axis_o;
    logic [7:0] cmd_addr_i = 8'h00, cmd_wdata_i = 8'h00, heat_i = 8'h00, cmd_rdata_o, rd;
    logic [11:0] acc_o, got, old, v, base = 12'h000, delta = 12'h000, fofs = 12'h000;
    logic [3:0] span_code_o;
    logic [4:0] bw_eff_o;
    accel_pkg::axis_vec_t raw_acc_i = '0, filt_acc_i = '0;
    int n_errors = 0, check_count = 0, i, j, k, e;
    logic [1:0] st_ax[4] = '{2'h1, 2'h2, 2'h3, 2'h3};
    logic [11:0] st_d[4] = '{12'd205, 12'd204, 12'd103, 12'd102};
    accel_reg_if bus_if();
    accel_device #(.TICK_CYC(10), .SETTLE_CYC(5)) u_accel_device (.clk_sys_i, .rst_i,
        .bus(bus_if.dev), .raw_acc_i, .filt_acc_i, .heat_i, .analog_pwr_o, .selftest_axis_o,
        .selftest_sign_o, .selftest_amp_o, .span_code_o, .span_valid_o, .bw_eff_o);
    accel_host #(.WAIT_CYC(20)) u_accel_host (.clk_sys_i, .rst_i, .bus(bus_if.host),
        .cmd_wr_i, .cmd_rd_i, .cmd_addr_i, .cmd_wdata_i, .cmd_rdata_o, .cmd_rvalid_o,
        .acc_rd_i, .acc_axis_i, .acc_o, .acc_fresh_o, .acc_valid_o, .st_go_i, .st_axis_i,
        .st_done_o, .st_pass_o, .busy_o);
    accel_readout_chk #(.WAIT_CYC(20)) u_accel_readout_chk (.clk_sys_i, .rst_i,
        .reg_addr(bus_if.reg_addr), .reg_wdata(bus_if.reg_wdata), .reg_wr(bus_if.reg_wr),
        .reg_rd(bus_if.reg_rd), .reg_rdata(bus_if.reg_rdata));
    always #2 clk_sys_i = ~clk_sys_i;
    // sensor stand-in: self-test in positive direction adds delta to every axis
    assign v = base + ((selftest_axis_o != 2'h0 && selftest_sign_o) ? delta : 12'h000);
    always @(posedge clk_sys_i) begin
        raw_acc_i <= {v + 12'h002, v + 12'h001, v};
        filt_acc_i <= {v + fofs, v + fofs, v + fofs};
    end
    ////////////////////////////////////////////////////////////
    function automatic logic [4:0] bw_exp(input logic [4:0] c);
        return c[4] ? 5'h0F : (c[3] ? c : 5'h08);
    endfunction : bw_exp
    function automatic int sleep_ticks(input logic [3:0] c);
        int t[16] = '{1, 1, 1, 1, 1, 1, 2, 4, 8, 12, 20, 50, 100, 200, 1000, 2000};
        return t[c];
    endfunction : sleep_ticks
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic cmd(input logic w, input logic [7:0] a, input logic [7:0] d);
        rd = 8'hXX;
        @(posedge clk_sys_i);
        cmd_wr_i <= w;
        cmd_rd_i <= !w;
        cmd_addr_i <= a;
        cmd_wdata_i <= d;
        @(posedge clk_sys_i);
        cmd_wr_i <= 1'b0;
        cmd_rd_i <= 1'b0;
        repeat (6) begin
            @(negedge clk_sys_i);
            if (cmd_rvalid_o === 1'b1) rd = cmd_rdata_o;
        end
    endtask : cmd
    task automatic acc(input logic [1:0] ax);
        got = 12'hXXX;
        fr = 1'bX;
        @(posedge clk_sys_i);
        acc_rd_i <= 1'b1;
        acc_axis_i <= ax;
        @(posedge clk_sys_i);
        acc_rd_i <= 1'b0;
        repeat (7) begin
            @(negedge clk_sys_i);
            if (acc_valid_o === 1'b1) {got, fr} = {acc_o, acc_fresh_o};
        end
    endtask : acc
    task automatic wait_pwr(input logic lvl);
        for (int n = 0; n < 25000 && analog_pwr_o !== lvl; n++) @(negedge clk_sys_i);
    endtask : wait_pwr
    task automatic test_done();
        $display("checks %0d, errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : test_done
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (100000) @(posedge clk_sys_i);
        n_errors++;
        test_done();
    end
    initial begin
        void'($urandom(64));
        heat_i = 8'($urandom);
        base = 12'($urandom_range(0, 1500));
        fofs = 12'($urandom_range(1, 200));
        repeat (8) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(negedge clk_sys_i);
        chk(span_code_o, 4'h3);
        chk(bw_eff_o, 5'h0F);
        for (i = 0; i < 16; i++) begin
            cmd(1'b1, 8'h0F, 8'(i));
            chk(span_valid_o, 1'(i inside {3, 5, 8, 12}));
            cmd(1'b0, 8'h0F, 8'h00);
        end
        for (i = 0; i < 32; i++) begin
            cmd(1'b1, 8'h10, 8'(i));
            chk(bw_eff_o, bw_exp(5'(i)));
            cmd(1'b0, 8'h10, 8'h00);
        end
        cmd(1'b1, 8'h0F, 8'h08);
        for (i = 0; i < 8; i++) begin
            cmd(1'b1, 8'h32, 8'h10 | 8'(i));
            chk({selftest_amp_o, selftest_sign_o, selftest_axis_o}, 4'h8 | 4'(i));
        end
        cmd(1'b1, 8'h32, 8'h00);
        chk(selftest_axis_o, 2'h0);
        // raw then filtered stream into the sample registers
        for (j = 0; j < 2; j++) begin
            cmd(1'b1, 8'h13, j ? 8'h00 : 8'h80);
            repeat (30) @(posedge clk_sys_i);
            acc(2'(3 - 2 * j));
            chk(got, j ? base + fofs : base + 12'h002);
            chk(fr, 1'b1);
        end
        cmd(1'b1, 8'h08, 8'h5A);
        cmd(1'b0, 8'h08, 8'h00);
        chk(rd, heat_i);
        cmd(1'b0, 8'h20, 8'h00);
        chk(rd, 8'h00);
        // locked, then unlocked: high byte after a new sample arrived in between
        cmd(1'b1, 8'h13, 8'h80);
        for (j = 0; j < 2; j++) begin
            repeat (30) @(posedge clk_sys_i);
            cmd(1'b0, 8'h02, 8'h00);
            chk({rd[7:4], rd[0]}, {base[3:0], 1'b1});
            old = base;
            base = base ^ 12'h5A0;
            repeat (30) @(posedge clk_sys_i);
            cmd(1'b0, 8'h03, 8'h00);
            chk(rd, j ? base[11:4] : old[11:4]);
            cmd(1'b1, 8'h13, 8'hC0);
        end
        for (i = 0; i < 4; i++) begin
            delta = st_d[i];
            @(posedge clk_sys_i);
            st_go_i <= 1'b1;
            st_axis_i <= st_ax[i];
            @(posedge clk_sys_i);
            st_go_i <= 1'b0;
            @(negedge clk_sys_i);
            chk(busy_o, 1'b1);
            for (k = 0; k < 400 && st_done_o !== 1'b1; k++) @(negedge clk_sys_i);
            chk(st_pass_o, !i[0]);
            chk({k < 400, busy_o}, 2'b10);
        end
        for (i = 0; i < 16; i++) begin
            cmd(1'b1, 8'h11, 8'h10 | 8'(i));
            wait_pwr(1'b1);
            wait_pwr(1'b0);
            for (k = 0; k < 25000 && analog_pwr_o === 1'b0; k++) @(negedge clk_sys_i);
            e = sleep_ticks(4'(i)) * 10;
            chk(k >= e - 1 && k <= e + 1, 1'b1);
        end
        cmd(1'b1, 8'h11, 8'h00);
        e = 0;
        repeat (40) begin
            @(negedge clk_sys_i);
            e += (analog_pwr_o !== 1'b1);
        end
        chk(e, 0);
        chk(analog_pwr_o, 1'b1);
        test_done();
    end
endmodule : accel_sample_readout_selftest_tb
`default_nettype wire
